// ===== hdl/counter_consts.svh
// constants for the counter mode select block
`ifndef COUNTER_CONSTS_SVH
`define COUNTER_CONSTS_SVH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_LOAD 8'h04
`define OFS_HOLD 8'h08
`define OFS_CMD 8'h0c
`define OFS_COUNT 8'h10
`define OFS_STATUS 8'h14

// mode register field positions
`define GATE_HI 15
`define GATE_LO 13
`define SPECIAL_BIT 7
`define RELOAD_BIT 6
`define REPEAT_BIT 5

// gate control field codes
`define GATE_NONE 3'h0
`define GATE_EDGE_A 3'h6
`define GATE_EDGE_B 3'h7

// command register bits
`define CMD_ARM 0
`define CMD_DISARM 1
`define CMD_LOAD 2

// status register bits
`define ST_ARMED 0
`define ST_TC 1
`define ST_RUN 2
`define ST_ALT 3
`define ST_LETTER_LO 8
`define ST_LETTER_HI 12

// reset values
`define MODE_RST 16'h0000
`define DATA_RST 16'h0000

// letter index weights
`define W_SPECIAL 5'h0c
`define W_RELOAD 5'h06
`define W_REPEAT 5'h03

`endif

// ===== hdl/counter_pkg.sv
// types shared by the counter mode select block
package counter_pkg;

	typedef enum logic [1:0] {
		GATE_OFF,
		GATE_LEVEL,
		GATE_EDGE
	} gate_use_t;

	typedef struct packed {
		gate_use_t gate_use;
		logic special;
		logic reload_src;
		logic repeat_on;
		logic [4:0] letter;
		logic retrig;
		logic steer;
		logic alternate;
		logic unused_mode;
	} mode_t;

	typedef struct packed {
		logic level;
		logic rise;
	} pin_t;

endpackage : counter_pkg

// ===== hdl/edge_sync.sv
// two-stage synchroniser with active-going edge pulse
`timescale 1ns/1ps
`include "counter_consts.svh"

module edge_sync (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic pin,
	output counter_pkg::pin_t sync
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (ce) begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// rising only; falling edges never reported
	assign sync.level = sync_q;
	assign sync.rise = sync_q & ~prev_q & ce;

endmodule : edge_sync

// ===== hdl/mode_decode.sv
// decodes the mode register into the lettered mode
`timescale 1ns/1ps
`include "counter_consts.svh"

module mode_decode (
	input wire logic [15:0] mode_reg,
	output counter_pkg::mode_t mode
);

	logic [2:0] gate_control_field;
	logic special_gate_bit;
	logic reload_source_bit;
	logic repetition_bit;
	logic [1:0] gate_weight;
	counter_pkg::gate_use_t gate_use;

	assign gate_control_field = mode_reg[`GATE_HI:`GATE_LO];
	assign special_gate_bit = mode_reg[`SPECIAL_BIT];
	assign reload_source_bit = mode_reg[`RELOAD_BIT];
	assign repetition_bit = mode_reg[`REPEAT_BIT];

	// gate field to usage class, 000 ignores the gate
	always_comb begin
		if (gate_control_field == `GATE_NONE) begin
			gate_use = counter_pkg::GATE_OFF;
			gate_weight = 2'h0;
		end else if (gate_control_field == `GATE_EDGE_A ||
				gate_control_field == `GATE_EDGE_B) begin
			gate_use = counter_pkg::GATE_EDGE;
			gate_weight = 2'h2;
		end else begin
			gate_use = counter_pkg::GATE_LEVEL;
			gate_weight = 2'h1;
		end
	end

	// one driver per struct field
	assign mode.gate_use = gate_use;

	// letter index 0 = A ... 23 = X
	assign mode.letter = (special_gate_bit ? `W_SPECIAL : 5'h00) +
		(reload_source_bit ? `W_RELOAD : 5'h00) +
		(repetition_bit ? `W_REPEAT : 5'h00) +
		{3'h0, gate_weight};
	assign mode.special = special_gate_bit;
	assign mode.reload_src = reload_source_bit;
	assign mode.repeat_on = repetition_bit;
	// modes n, o, q, r
	assign mode.retrig = special_gate_bit & ~reload_source_bit &
		(gate_weight != 2'h0);
	// modes s, v
	assign mode.steer = special_gate_bit & reload_source_bit &
		(gate_weight == 2'h0);
	assign mode.alternate = ~special_gate_bit & reload_source_bit;
	// m, p, t, u, w have no defined behaviour
	assign mode.unused_mode = special_gate_bit &
		((~reload_source_bit & gate_weight == 2'h0) |
		(reload_source_bit & gate_weight != 2'h0 &
		~(repetition_bit & gate_weight == 2'h2)));

endmodule : mode_decode

// ===== hdl/counter_mode_select_logic.sv
// one counter with mode select, arm control and apb registers
`timescale 1ns/1ps
`include "counter_consts.svh"

module counter_mode_select_logic #(
	parameter int CW = 16
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic source_in,
	input wire logic gate_in,
	output logic tc_out
);

	counter_pkg::mode_t mode;
	counter_pkg::pin_t src;
	counter_pkg::pin_t gate;

	logic [15:0] mode_q;
	logic [CW-1:0] load_q;
	logic [CW-1:0] hold_q;
	logic [CW-1:0] count_q;
	logic terminal_count_state_q;
	logic armed_q;
	logic running_q;
	logic alt_q;
	logic [31:0] prdata_q;
	logic slverr_q;

	logic wr_en;
	logic rd_setup;
	logic arm_cmd;
	logic disarm_cmd;
	logic load_cmd;
	logic mode_wr;
	logic load_wr;
	logic hold_wr;
	logic cmd_wr;
	logic gate_ok;
	logic count_edge;
	logic leave_tc;
	logic stop_due;
	logic retrigger;
	logic [CW-1:0] reload_val;
	logic [31:0] status;

	// address check shared by read and write
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `OFS_MODE) || (a == `OFS_LOAD) ||
			(a == `OFS_HOLD) || (a == `OFS_CMD) ||
			(a == `OFS_COUNT) || (a == `OFS_STATUS);
	endfunction : mapped

	// widen a counter value to the bus word
	function automatic logic [31:0] widen(input logic [CW-1:0] v);
		widen = 32'(v);
	endfunction : widen

	mode_decode u_decode (
		.mode_reg(mode_q),
		.mode(mode)
	);

	// source pin: two flops then a rise detector
	edge_sync u_src (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.pin(source_in),
		.sync(src)
	);

	// gate pin, same crossing as the source
	edge_sync u_gate (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.pin(gate_in),
		.sync(gate)
	);

	// apb strobes, zero wait states
	// no stall: the host always sees one access cycle
	assign wr_en = psel & penable & pwrite & ce;
	assign rd_setup = psel & ~penable & ce;
	assign pready = 1'b1;
	assign pslverr = slverr_q & psel & penable;

	// register write strobes, one per writable word
	assign mode_wr = wr_en & (paddr == `OFS_MODE);
	assign load_wr = wr_en & (paddr == `OFS_LOAD);
	assign hold_wr = wr_en & (paddr == `OFS_HOLD);
	assign cmd_wr = wr_en & (paddr == `OFS_CMD);

	// command register strobes
	assign arm_cmd = cmd_wr & pwdata[`CMD_ARM];
	assign disarm_cmd = cmd_wr & pwdata[`CMD_DISARM];
	assign load_cmd = cmd_wr & pwdata[`CMD_LOAD];

	// gating per gate usage class
	always_comb begin
		case (mode.gate_use)
			counter_pkg::GATE_OFF: gate_ok = 1'b1;
			counter_pkg::GATE_LEVEL: gate_ok = gate.level;
			default: gate_ok = running_q;
		endcase
	end

	// tc state counts whatever the arming or gating
	// unused letters never start a count, only finish one
	assign count_edge = src.rise & (terminal_count_state_q |
		(armed_q & gate_ok & ~mode.unused_mode));
	assign leave_tc = count_edge & terminal_count_state_q;

	// alternate-reload modes stop on the second tc
	assign stop_due = ~mode.alternate | alt_q;

	// retrigger on gate edge only while armed
	assign retrigger = mode.retrig & gate.rise & armed_q;

	// reload source chosen at tc exit
	always_comb begin
		if (mode.steer) begin
			reload_val = gate.level ? hold_q : load_q;
		end else if (mode.alternate) begin
			reload_val = alt_q ? hold_q : load_q;
		end else begin
			reload_val = load_q;
		end
	end

	// mode register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= `MODE_RST;
		end else if (mode_wr) begin
			mode_q <= pwdata[15:0];
		end
	end

	// load register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			load_q <= CW'(`DATA_RST);
		end else if (load_wr) begin
			load_q <= pwdata[CW-1:0];
		end
	end

	// hold register, hardware capture beats software write
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_q <= CW'(`DATA_RST);
		end else if (retrigger) begin
			hold_q <= count_q;
		end else if (hold_wr) begin
			hold_q <= pwdata[CW-1:0];
		end
	end

	// down counter with reloads
	// a counted edge beats a same-cycle load command
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= CW'(`DATA_RST);
		end else if (ce) begin
			if (retrigger) begin
				count_q <= load_q;
			end else if (leave_tc) begin
				count_q <= reload_val;
			end else if (count_edge) begin
				count_q <= count_q - CW'(1);
			end else if (load_cmd) begin
				count_q <= load_q;
			end
		end
	end

	// terminal count state: entered on the edge that hits zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			terminal_count_state_q <= 1'b0;
		end else if (ce) begin
			if (retrigger || leave_tc) begin
				terminal_count_state_q <= 1'b0;
			end else if (count_edge && count_q == CW'(1)) begin
				terminal_count_state_q <= 1'b1; // set beats load
			end else if (load_cmd) begin
				terminal_count_state_q <= 1'b0;
			end
		end
	end

	// alternate reload phase, toggles on each tc exit
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			alt_q <= 1'b0;
		end else if (ce) begin
			if (!mode.alternate || arm_cmd) begin
				alt_q <= 1'b0;
			end else if (leave_tc) begin
				alt_q <= ~alt_q;
			end
		end
	end

	// arm state, arm command wins over a same-cycle disarm
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else if (ce) begin
			if (arm_cmd) begin
				armed_q <= 1'b1;
			end else if (disarm_cmd) begin
				armed_q <= 1'b0;
			end else if (leave_tc && !mode.repeat_on && stop_due) begin
				armed_q <= 1'b0;
			end
		end
	end
	// repeat set: armed_q untouched at tc exit

	// edge gated run flag: started by gate edge, stopped after tc
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			running_q <= 1'b0;
		end else if (ce) begin
			if (mode.gate_use != counter_pkg::GATE_EDGE) begin
				running_q <= 1'b0;
			end else if (gate.rise && armed_q) begin
				running_q <= 1'b1;
			end else if (leave_tc && stop_due) begin
				running_q <= 1'b0;
			end
		end
	end

	// status word
	// bits outside the listed fields read as zero
	always_comb begin
		status = 32'h0000_0000;
		status[`ST_ARMED] = armed_q;
		status[`ST_TC] = terminal_count_state_q;
		status[`ST_RUN] = running_q;
		status[`ST_ALT] = alt_q;
		status[`ST_LETTER_HI:`ST_LETTER_LO] = mode.letter;
	end

	// read data captured in setup phase
	// word frozen at setup so the access phase sees it stable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (rd_setup) begin
			slverr_q <= ~mapped(paddr);
			if (pwrite) begin
				prdata_q <= 32'h0000_0000;
			end else if (paddr == `OFS_MODE) begin
				prdata_q <= {16'h0000, mode_q};
			end else if (paddr == `OFS_LOAD) begin
				prdata_q <= widen(load_q);
			end else if (paddr == `OFS_HOLD) begin
				prdata_q <= widen(hold_q);
			end else if (paddr == `OFS_COUNT) begin
				prdata_q <= widen(count_q);
			end else if (paddr == `OFS_STATUS) begin
				prdata_q <= status;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// read data straight from the capture flop
	assign prdata = prdata_q;

	// terminal count pin from the state flop
	assign tc_out = terminal_count_state_q;

endmodule : counter_mode_select_logic

// ===== tb/host_model.sv
// apb host model issuing mode writes and arm commands
`timescale 1ns/1ps
module host_model (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// setup, access held until pready, then one idle edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : xfer
endmodule : host_model

// ===== tb/counter_mode_select_logic_assertions.sv
// port checks for the counter mode select block
`timescale 1ns/1ps
`include "counter_consts.svh"
module counter_mode_select_logic_assertions #(
	parameter int CW = 16
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic source_in,
	input wire logic gate_in,
	input wire logic tc_out
);
	logic [15:0] mode_q;
	logic wr_acc;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	assign wr_acc = psel & penable & pwrite;

	// shadow of the mode register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= `MODE_RST;
		end else if (ce && wr_acc && paddr == `OFS_MODE) begin
			mode_q <= pwdata[15:0];
		end
	end

	pready_on_a: assert property (pready)
		else $error("pready low");
	err_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	unmapped_err_a: assert property (
		psel && penable && paddr > `OFS_STATUS |-> pslverr)
		else $error("unmapped access not refused");
	upper_zero_a: assert property (
		psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	mode_echo_a: assert property (
		psel && penable && !pwrite && paddr == `OFS_MODE |->
		prdata[15:0] == mode_q)
		else $error("mode readback wrong");
	status_tc_a: assert property (
		psel && penable && !pwrite && paddr == `OFS_STATUS |->
		prdata[`ST_TC] == $past(tc_out))
		else $error("status tc bit wrong");
	tc_rise_src_a: assert property (
		$rose(tc_out) |-> $past(source_in, 3) && !$past(source_in, 4))
		else $error("tc without source edge");
	tc_fall_cause_a: assert property (
		$fell(tc_out) |->
		($past(source_in, 3) && !$past(source_in, 4)) ||
		($past(gate_in, 3) && !$past(gate_in, 4)) || $past(wr_acc))
		else $error("tc left without cause");
endmodule : counter_mode_select_logic_assertions

bind counter_mode_select_logic counter_mode_select_logic_assertions #(.CW(CW)) chk_u (
	.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.source_in(source_in), .gate_in(gate_in), .tc_out(tc_out)
);

// ===== tb/counter_mode_select_logic_tb.sv
// self-checking bench for the counter mode select block
`timescale 1ns/1ps
`include "counter_consts.svh"
module counter_mode_select_logic_tb;
	logic sys_clk, resetn, ce, psel, penable, pwrite, pready, pslverr;
	logic source_in, gate_in, tc_out, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] seed = 32'h1e3c;
	logic [15:0] m;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	host_model host_u (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	counter_mode_select_logic #(.CW(16)) dut_u (.sys_clk(sys_clk),
		.resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_in(source_in),
		.gate_in(gate_in), .tc_out(tc_out));

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			end_sim();
		end
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	// expected mode letter, 0 = A
	function automatic logic [4:0] letter(logic [15:0] v);
		logic [4:0] g;
		g = (v[15:13] == 3'h0) ? 5'h00 :
			(v[15:14] == 2'h3) ? 5'h02 : 5'h01;
		return g + (v[7] ? `W_SPECIAL : 5'h00) +
			(v[6] ? `W_RELOAD : 5'h00) + (v[5] ? `W_REPEAT : 5'h00);
	endfunction : letter

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		host_u.xfer(1'b1, a, {16'h0, d}, rd, er);
	endtask : wr

	task rc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		host_u.xfer(1'b0, a, 32'h0, rd, er);
		chk(rd & k, e);
	endtask : rc

	// source pulses, falling half included
	task pulse(input int n);
		repeat (n) begin
			source_in <= 1'b1;
			repeat (4) @(posedge sys_clk);
			source_in <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
	endtask : pulse

	task gt(input logic v);
		gate_in <= v;
		repeat (4) @(posedge sys_clk);
	endtask : gt

	task end_sim();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		source_in = 1'b0;
		gate_in = 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rc(`OFS_MODE, 32'hffffffff, 32'h0);
		// decode of corner and random modes
		for (int i = 0; i < 24; i++) begin
			m = (i == 0) ? 16'h1f1f : rnd();
			wr(`OFS_MODE, m);
			rc(`OFS_STATUS, 32'h1f00, 32'(letter(m)) << 8);
		end
		$display("test decode done");
		// mode a: arm, count down, reload, disarm
		wr(`OFS_MODE, 16'h0000);
		wr(`OFS_LOAD, 16'h0003);
		wr(`OFS_CMD, 16'h0004);
		pulse(2);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		wr(`OFS_CMD, 16'h0001);
		for (int i = 3; i > 0; i--) begin
			gate_in <= ^rnd();
			pulse(1);
			rc(`OFS_COUNT, 32'hffff, 32'(i - 1));
		end
		chk({31'h0, tc_out}, 32'h1);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		rc(`OFS_STATUS, 32'h3, 32'h0);
		pulse(2);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		wr(`OFS_CMD, 16'h0001);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h2);
		$display("test single strobe done");
		// mode d: repeats through terminal counts
		wr(`OFS_MODE, 16'h0020);
		wr(`OFS_LOAD, 16'h0002);
		wr(`OFS_CMD, 16'h0005);
		pulse(5);
		rc(`OFS_STATUS, 32'h3, 32'h3);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h2);
		$display("test repeat done");
		// mode n: gate edge copies count to hold, reloads
		gt(1'b0);
		wr(`OFS_MODE, 16'h2080);
		wr(`OFS_LOAD, 16'h0005);
		wr(`OFS_CMD, 16'h0005);
		gt(1'b1);
		pulse(2);
		gt(1'b0);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		gt(1'b1);
		rc(`OFS_HOLD, 32'hffff, 32'h3);
		rc(`OFS_COUNT, 32'hffff, 32'h5);
		$display("test retrigger done");
		// mode v: gate level steers the reload source
		gt(1'b0);
		wr(`OFS_MODE, 16'h00e0);
		wr(`OFS_HOLD, 16'h0007);
		wr(`OFS_LOAD, 16'h0002);
		wr(`OFS_CMD, 16'h0005);
		pulse(3);
		rc(`OFS_COUNT, 32'hffff, 32'h2);
		pulse(2);
		gt(1'b1);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h7);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h6);
		host_u.xfer(1'b0, 8'h40, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
		$display("test steer done");
		// clock enable low freezes the counter
		ce <= 1'b0;
		pulse(1);
		ce <= 1'b1;
		rc(`OFS_COUNT, 32'hffff, 32'h6);
		$display("test freeze done");
		// mode o: gate edge starts, stop and disarm after tc
		gt(1'b0);
		wr(`OFS_MODE, 16'hc080);
		wr(`OFS_LOAD, 16'h0003);
		wr(`OFS_CMD, 16'h0005);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		gt(1'b1);
		pulse(3);
		rc(`OFS_STATUS, 32'h7, 32'h7);
		pulse(1);
		rc(`OFS_STATUS, 32'h7, 32'h0);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		wr(`OFS_CMD, 16'h0001);
		gt(1'b0);
		pulse(1);
		rc(`OFS_COUNT, 32'hffff, 32'h3);
		$display("test edge start done");
		// reset in mid-run clears mode and arming
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rc(`OFS_MODE, 32'hffff, 32'h0);
		pulse(1);
		rc(`OFS_STATUS, 32'h1f07, 32'h0);
		rc(`OFS_COUNT, 32'hffff, 32'h0);
		$display("test reset done");
		end_sim();
	end
endmodule : counter_mode_select_logic_tb
